// *** include/mcg_pkg.sv ***
// Contract
// - Master clock comes from external input pin
// - All clocks but the serial bit clock come from dividers
// - Sync by counter phase shifts, not clock
// - Two coupled loops: transmit and receive
// - Transmit and receive symbol and data rates programmed independently; sample rates fixed
// - Transmit loop self-tunes without host help
// - Receive loop is host-stepped phase shifter
// - Receive clocks follow transmit clock shifts
// - Transmit timing: master, slave or free-running
// - External transmit data clock followed in slave
// - Symbol clock rates from 75 to 3429
// - Data clock rates from 75 to 33600
// - Serial words are 16-bit two's complement
// - Two serial channels, each in, out, sync
// - Device drives shared serial bit clock
// - Output data and sample clocks, tx doubled
package mcg_pkg;

    // ****************************************************************
    // Clocking
    // ****************************************************************
    localparam int unsigned SYS_CLK_HZ = 40_000_000;
    // Sample rate is fixed here; the transmit side runs at twice it
    localparam int unsigned SAMPLE_HZ  = 9600;
    localparam int unsigned CNT_W      = 24;
    // Floor on a half period keeps a two-cycle advance from skipping a toggle
    localparam int unsigned HALF_MIN   = 4;

    // ****************************************************************
    // Rate tables
    // ****************************************************************
    localparam int unsigned SYM_NUM  = 11;
    localparam int unsigned DATA_NUM = 18;
    localparam int unsigned SYM_HZ [SYM_NUM] = '{75, 300, 600, 1200, 1600, 2400,
                                                 2743, 2800, 3000, 3200, 3429};
    localparam int unsigned DATA_HZ [DATA_NUM] = '{75, 300, 600, 1200, 2400, 4800,
                                                   7200, 9600, 12000, 14400, 16800,
                                                   19200, 21600, 24000, 26400, 28800,
                                                   31200, 33600};

    // ****************************************************************
    // Divider slots
    // ****************************************************************
    localparam int unsigned NDIV     = 6;
    localparam int unsigned DIV_TXS2 = 0;
    localparam int unsigned DIV_TXY  = 1;
    localparam int unsigned DIV_TXD  = 2;
    localparam int unsigned DIV_RXS  = 3;
    localparam int unsigned DIV_RXY  = 4;
    localparam int unsigned DIV_RXD  = 5;
    localparam int unsigned NTX      = 3;

    // ****************************************************************
    // Serial link and loops
    // ****************************************************************
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned BITC_W    = 5;
    localparam int unsigned STEP_W    = 4;
    localparam logic [3:0]  TUNE_MAX  = 4'h8;
    localparam logic [1:0]  D_HOLD    = 2'h0;
    localparam logic [1:0]  D_NORM    = 2'h1;
    localparam logic [1:0]  D_FAST    = 2'h2;

    typedef enum logic [1:0] {MCG_TX_MASTER, MCG_TX_SLAVE, MCG_TX_FREE} mcg_tx_mode_e;

    function automatic logic [CNT_W-1:0] half_cnt(input int unsigned clk_hz,
                                                 input int unsigned rate_hz);
        int unsigned h;
        h = (clk_hz / rate_hz + 1) / 2;
        if (h < HALF_MIN) begin
            h = HALF_MIN;
        end
        return h[CNT_W-1:0];
    endfunction : half_cnt

endpackage : mcg_pkg

// *** logic/mcg_pair_buf.sv ***
`timescale 1ns/1ps
module mcg_pair_buf #(
    parameter int unsigned P_W     = 16,
    parameter int unsigned P_DEPTH = 2
) (
    input  wire logic           i_clk_sys,
    input  wire logic           i_rst_n,
    input  wire logic [P_W-1:0] i_in_data,
    input  wire logic           i_in_valid,
    output logic                o_in_ready,
    output logic [P_W-1:0]      o_out_data,
    output logic                o_out_valid,
    input  wire logic           i_out_ready
);
    localparam int unsigned PW = $clog2(P_DEPTH);
    localparam int unsigned CW = $clog2(P_DEPTH + 1);

    typedef struct packed {
        logic [P_DEPTH-1:0][P_W-1:0] mem;
        logic [PW-1:0]               wptr;
        logic [PW-1:0]               rptr;
        logic [CW-1:0]               count;
        logic                        rdy;
    } mcg_buf_s;

    mcg_buf_s st;
    mcg_buf_s nxt;
    logic     push;
    logic     pop;

    assign push        = i_in_valid && st.rdy;
    assign pop         = i_out_ready && (st.count != '0);
    assign o_in_ready  = st.rdy;
    assign o_out_valid = st.count != '0;
    assign o_out_data  = st.mem[st.rptr];

    // ****************************************************************
    // Storage
    // ****************************************************************
    always_comb begin
        nxt = st;
        if (push) begin
            nxt.mem[st.wptr] = i_in_data;
            nxt.wptr         = (st.wptr == PW'(P_DEPTH - 1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop) begin
            nxt.rptr = (st.rptr == PW'(P_DEPTH - 1)) ? '0 : st.rptr + 1'b1;
        end
        nxt.count = st.count + CW'(push) - CW'(pop);
        // Registered ready: a full buffer refuses the next word outright
        nxt.rdy   = nxt.count != CW'(P_DEPTH);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st     <= '0;
            st.rdy <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    a_buf_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st.count == CW'(P_DEPTH)) |-> !o_in_ready)
        else $error("Buffer full yet ready");

endmodule : mcg_pair_buf

// *** logic/mcg_clock_gen.sv ***
`timescale 1ns/1ps
module mcg_clock_gen #(
    parameter int unsigned P_CLK_HZ    = mcg_pkg::SYS_CLK_HZ,
    parameter int unsigned P_SAMPLE_HZ = mcg_pkg::SAMPLE_HZ
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire mcg_pkg::mcg_tx_mode_e i_tx_mode,
    input  wire logic [3:0]           i_tx_symbol_sel,
    input  wire logic [4:0]           i_tx_data_sel,
    input  wire logic [3:0]           i_rx_symbol_sel,
    input  wire logic [4:0]           i_rx_data_sel,
    input  wire logic                 i_external_tx_data_clock,
    input  wire logic                 i_rx_step_req,
    input  wire logic                 i_rx_step_dir,
    input  wire logic                 i_tx_frame_sync_in,
    input  wire logic                 i_tx_channel_data_in,
    input  wire logic                 i_rx_frame_sync_in,
    input  wire logic                 i_rx_channel_data_in,
    input  wire logic [15:0]          i_adc_word,
    input  wire logic                 i_adc_valid,
    output logic                      o_adc_ready,
    output logic                      o_serial_bit_clock,
    output logic                      o_tx_channel_data_out,
    output logic                      o_rx_channel_data_out,
    output logic                      o_tx_data_clock_out,
    output logic                      o_tx_sample_clock_double,
    output logic                      o_tx_symbol_clock,
    output logic                      o_rx_data_clock_out,
    output logic                      o_rx_sample_clock_out,
    output logic                      o_rx_symbol_clock,
    output logic                      o_tx_timing_source,
    output logic [15:0]               o_dac_word,
    output logic                      o_dac_valid,
    output logic [15:0]               o_rx_ctrl_word,
    output logic                      o_rx_ctrl_valid
);
    localparam int unsigned NDIV  = mcg_pkg::NDIV;
    localparam int unsigned CNT_W = mcg_pkg::CNT_W;
    localparam int unsigned WB    = mcg_pkg::WORD_BITS;
    localparam int unsigned BW    = mcg_pkg::BITC_W;
    localparam int unsigned SW    = mcg_pkg::STEP_W;

    typedef struct packed {
        logic [NDIV-1:0][CNT_W-1:0] cnt;
        logic [NDIV-1:0]            clk;
        logic                       sclk;
        logic                       ext_q;
        logic [1:0]                 fs_q;
        logic [1:0][BW-1:0]         bitc;
        logic [1:0][WB-1:0]         sh_in;
        logic [1:0][WB-1:0]         sh_out;
        logic [1:0]                 dout;
        logic [1:0][WB-1:0]         word;
        logic [1:0]                 wvalid;
        logic [WB-1:0]              echo;
        logic [SW-1:0]              tune;
        logic                       tune_dir;
        logic                       tune_seen;
        logic [SW-1:0]              tx_pend;
        logic                       tx_dir;
        logic                       rx_pend;
        logic                       rx_dir;
        logic                       src;
    } mcg_state_s;

    mcg_state_s               st;
    mcg_state_s               nxt;
    logic [NDIV-1:0][CNT_W-1:0] half;
    logic [1:0]               d_tx;
    logic [1:0]               d_rx;
    logic                     rx_apply;
    logic                     ext_rise;
    logic [1:0]               start;
    logic [WB-1:0]            buf_data;
    logic                     buf_valid;
    logic                     buf_take;

    // ****************************************************************
    // Rate selection
    // ****************************************************************
    function automatic logic [CNT_W-1:0] sym_half(input logic [3:0] sel);
        sym_half = mcg_pkg::half_cnt(P_CLK_HZ, mcg_pkg::SYM_HZ[0]);
        for (int k = 0; k < mcg_pkg::SYM_NUM; k++) begin
            if (sel == k[3:0]) begin
                sym_half = mcg_pkg::half_cnt(P_CLK_HZ, mcg_pkg::SYM_HZ[k]);
            end
        end
    endfunction : sym_half

    function automatic logic [CNT_W-1:0] data_half(input logic [4:0] sel);
        data_half = mcg_pkg::half_cnt(P_CLK_HZ, mcg_pkg::DATA_HZ[0]);
        for (int k = 0; k < mcg_pkg::DATA_NUM; k++) begin
            if (sel == k[4:0]) begin
                data_half = mcg_pkg::half_cnt(P_CLK_HZ, mcg_pkg::DATA_HZ[k]);
            end
        end
    endfunction : data_half

    // Independent selects per direction allow asymmetric rates
    assign half[mcg_pkg::DIV_TXS2] = mcg_pkg::half_cnt(P_CLK_HZ, 2 * P_SAMPLE_HZ);
    assign half[mcg_pkg::DIV_TXY]  = sym_half(i_tx_symbol_sel);
    assign half[mcg_pkg::DIV_TXD]  = data_half(i_tx_data_sel);
    assign half[mcg_pkg::DIV_RXS]  = mcg_pkg::half_cnt(P_CLK_HZ, P_SAMPLE_HZ);
    assign half[mcg_pkg::DIV_RXY]  = sym_half(i_rx_symbol_sel);
    assign half[mcg_pkg::DIV_RXD]  = data_half(i_rx_data_sel);

    // ****************************************************************
    // Phase adjustment
    // ****************************************************************
    // Step 0 holds a counter one master period, step 2 advances it one
    assign d_tx = (st.tx_pend != '0) ? (st.tx_dir ? mcg_pkg::D_FAST : mcg_pkg::D_HOLD)
                                     : mcg_pkg::D_NORM;
    // Host step waits for the sample boundary and for a quiet transmit loop
    assign rx_apply = st.rx_pend && (d_tx == mcg_pkg::D_NORM)
                      && (st.cnt[mcg_pkg::DIV_RXS] == CNT_W'(1))
                      && st.clk[mcg_pkg::DIV_RXS];
    assign d_rx = !rx_apply ? d_tx
                : (st.rx_dir ? mcg_pkg::D_FAST : mcg_pkg::D_HOLD);
    assign ext_rise = i_external_tx_data_clock && !st.ext_q;

    // ****************************************************************
    // Serial frame detect
    // ****************************************************************
    // Frames are seen only at falling bit-clock edges, where host data is stable
    assign start[0] = st.sclk && st.fs_q[0] && !i_tx_frame_sync_in && (st.bitc[0] == '0);
    assign start[1] = st.sclk && st.fs_q[1] && !i_rx_frame_sync_in && (st.bitc[1] == '0);
    assign buf_take = start[1] && buf_valid;

    mcg_pair_buf #(
        .P_W     (WB),
        .P_DEPTH (2)
    ) u_adc_buf (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_in_data   (i_adc_word),
        .i_in_valid  (i_adc_valid),
        .o_in_ready  (o_adc_ready),
        .o_out_data  (buf_data),
        .o_out_valid (buf_valid),
        .i_out_ready (buf_take)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic          din;
        logic [WB-1:0] shifted;
        din     = 1'b0;
        shifted = '0;
        nxt     = st;

        for (int i = 0; i < NDIV; i++) begin
            if (st.cnt[i] <= CNT_W'((i < mcg_pkg::NTX) ? d_tx : d_rx)) begin
                nxt.clk[i] = !st.clk[i];
                nxt.cnt[i] = st.cnt[i] + half[i]
                           - CNT_W'((i < mcg_pkg::NTX) ? d_tx : d_rx);
            end else begin
                nxt.cnt[i] = st.cnt[i] - CNT_W'((i < mcg_pkg::NTX) ? d_tx : d_rx);
            end
        end

        nxt.ext_q = i_external_tx_data_clock;
        nxt.src   = (i_tx_mode == mcg_pkg::MCG_TX_MASTER);
        if (st.tx_pend != '0) begin
            nxt.tx_pend = st.tx_pend - 1'b1;
        end else if (ext_rise && (i_tx_mode == mcg_pkg::MCG_TX_SLAVE)) begin
            // Own clock already high means it rose early, so hold it back
            nxt.tx_dir    = !st.clk[mcg_pkg::DIV_TXD];
            nxt.tune_seen = 1'b1;
            // Repeated errors one way lengthen the correction burst
            if (st.tune_seen && (st.tune_dir == nxt.tx_dir)) begin
                nxt.tune = (st.tune < SW'(mcg_pkg::TUNE_MAX)) ? st.tune + 1'b1 : st.tune;
            end else begin
                nxt.tune = SW'(1);
            end
            nxt.tune_dir = nxt.tx_dir;
            nxt.tx_pend  = nxt.tune;
        end

        // A request in the apply cycle is kept: set wins over clear
        if (rx_apply) begin
            nxt.rx_pend = 1'b0;
        end
        if (i_rx_step_req) begin
            nxt.rx_pend = 1'b1;
            nxt.rx_dir  = i_rx_step_dir;
        end

        nxt.sclk   = !st.sclk;
        nxt.wvalid = '0;
        for (int ch = 0; ch < 2; ch++) begin
            din     = (ch == 0) ? i_tx_channel_data_in : i_rx_channel_data_in;
            shifted = {st.sh_in[ch][WB-2:0], din};
            if (st.sclk) begin
                nxt.fs_q[ch] = (ch == 0) ? i_tx_frame_sync_in : i_rx_frame_sync_in;
                if (start[ch]) begin
                    nxt.bitc[ch]   = BW'(WB);
                    nxt.sh_out[ch] = (ch == 0) ? st.echo : (buf_take ? buf_data : '0);
                end else if (st.bitc[ch] != '0) begin
                    nxt.sh_in[ch] = shifted;
                    nxt.bitc[ch]  = st.bitc[ch] - 1'b1;
                    if (st.bitc[ch] == BW'(1)) begin
                        nxt.word[ch]   = shifted;
                        nxt.wvalid[ch] = 1'b1;
                        if (ch == 0) begin
                            nxt.echo = shifted;
                        end
                    end
                end
            end else if (st.bitc[ch] != '0) begin
                // Launch on the rising edge so the host can sample on the fall
                nxt.dout[ch]   = st.sh_out[ch][WB-1];
                nxt.sh_out[ch] = {st.sh_out[ch][WB-2:0], 1'b0};
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st      <= '0;
            st.cnt  <= {NDIV{CNT_W'(1)}};
            st.fs_q <= 2'h3;
            st.src  <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_serial_bit_clock       = st.sclk;
    assign o_tx_channel_data_out    = st.dout[0];
    assign o_rx_channel_data_out    = st.dout[1];
    assign o_tx_sample_clock_double = st.clk[mcg_pkg::DIV_TXS2];
    assign o_tx_symbol_clock        = st.clk[mcg_pkg::DIV_TXY];
    assign o_tx_data_clock_out      = st.clk[mcg_pkg::DIV_TXD];
    assign o_rx_sample_clock_out    = st.clk[mcg_pkg::DIV_RXS];
    assign o_rx_symbol_clock        = st.clk[mcg_pkg::DIV_RXY];
    assign o_rx_data_clock_out      = st.clk[mcg_pkg::DIV_RXD];
    assign o_tx_timing_source       = st.src;
    assign o_dac_word               = st.word[0];
    assign o_dac_valid              = st.wvalid[0];
    assign o_rx_ctrl_word           = st.word[1];
    assign o_rx_ctrl_valid          = st.wvalid[1];

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_sclk_period: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_serial_bit_clock |=> !o_serial_bit_clock ##1 o_serial_bit_clock)
        else $error("Serial bit clock not a two-cycle square wave");

    a_word_length: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st.bitc[0] == BW'(WB) && $past(st.bitc[0]) == '0) |-> ##32 o_dac_valid)
        else $error("Transmit channel word not sixteen bits");

    a_msb_first: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st.bitc[1] == BW'(WB) && $past(st.bitc[1]) == '0)
        |-> ##1 (o_rx_channel_data_out == $past(st.sh_out[1][WB-1])))
        else $error("Receive channel MSB not launched first");

    a_tune_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (ext_rise && i_tx_mode == mcg_pkg::MCG_TX_SLAVE && st.tx_pend == '0)
        |=> (st.tx_pend != '0))
        else $error("Slave edge did not start a correction");

    a_no_track: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_tx_mode != mcg_pkg::MCG_TX_SLAVE && st.tx_pend == '0) |=> (st.tx_pend == '0))
        else $error("Correction outside slave mode");

    a_rx_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (d_tx != mcg_pkg::D_NORM) |-> (d_rx == d_tx))
        else $error("Receive clocks lost transmit shift");

    a_rx_request: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_rx_step_req |=> (st.rx_pend && st.rx_dir == $past(i_rx_step_dir)))
        else $error("Host step request lost");

    a_tune_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st.tune <= SW'(mcg_pkg::TUNE_MAX))
        else $error("Tune step above limit");

    a_cnt_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (st.cnt[mcg_pkg::DIV_TXD] != '0)
        && (st.cnt[mcg_pkg::DIV_TXD] <= half[mcg_pkg::DIV_TXD] + CNT_W'(2)))
        else $error("Transmit data divider out of range");

endmodule : mcg_clock_gen

// *** dv/mcg_host_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Host serial port, both channels framed in lockstep
// ****************************************************************
module mcg_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_sclk,
    input  wire logic i_tx_do,
    input  wire logic i_rx_do,
    output logic      o_tx_fs,
    output logic      o_rx_fs,
    output logic      o_tx_di,
    output logic      o_rx_di
);
    initial begin
        o_tx_fs = 1'b1;
        o_rx_fs = 1'b1;
        o_tx_di = 1'b0;
        o_rx_di = 1'b1;
    end

    task automatic xfer(input logic [15:0] wt, input logic [15:0] wr,
                        output logic [15:0] gt, output logic [15:0] gr);
        do @(posedge i_clk_sys); while (i_sclk !== 1'b0);
        o_tx_fs <= 1'b0;
        o_rx_fs <= 1'b0;
        @(posedge i_clk_sys);
        o_tx_fs <= 1'b1;
        o_rx_fs <= 1'b1;
        for (int i = 15; i >= 0; i--) begin
            @(posedge i_clk_sys);
            o_tx_di <= wt[i];
            o_rx_di <= wr[i];
            @(posedge i_clk_sys);
            gt[i] = i_tx_do;
            gr[i] = i_rx_do;
        end
        // Idle lines flip so a stale last bit is never mistaken for data
        o_tx_di <= ~o_tx_di;
        o_rx_di <= ~o_rx_di;
    endtask : xfer
endmodule : mcg_host_model

// *** dv/tb_modem_afe_clock_dpll_generator.sv ***
`timescale 1ns/1ps
module tb_modem_afe_clock_dpll_generator;
    // ****************************************************************
    // Bench
    // ****************************************************************
    // Slow divider base keeps the 75 Hz phases short enough to measure
    localparam int CLK_HZ  = 400000;
    localparam int SMP     = mcg_pkg::SAMPLE_HZ;
    localparam int MAP [6] = '{3, 1, 6, 4, 2, 5};
    localparam int SYM [11] = '{75, 300, 600, 1200, 1600, 2400, 2743, 2800, 3000, 3200, 3429};
    localparam int DAT [18] = '{75, 300, 600, 1200, 2400, 4800, 7200, 9600, 12000, 14400,
                                16800, 19200, 21600, 24000, 26400, 28800, 31200, 33600};
    logic                  clk, rst_n, adc_valid, tx_frame_sync_in, rx_frame_sync_in, tdi, rdi, tdo, rdo;
    logic                  ext_clk, step_req, step_dir;
    mcg_pkg::mcg_tx_mode_e mode;
    logic [3:0]            tsym, rsym;
    logic [4:0]            tdat, rdat;
    logic [15:0]           adc_word, dac_word, rctl_word;
    wire  [10:0]           ck;
    int                    err_total, num_checks, cyc;

    mcg_clock_gen #(.P_CLK_HZ(CLK_HZ)) DUT (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_tx_mode(mode), .i_tx_symbol_sel(tsym),
        .i_tx_data_sel(tdat), .i_rx_symbol_sel(rsym), .i_rx_data_sel(rdat),
        .i_external_tx_data_clock(ext_clk), .i_rx_step_req(step_req), .i_rx_step_dir(step_dir),
        .i_tx_frame_sync_in(tx_frame_sync_in), .i_tx_channel_data_in(tdi), .i_rx_frame_sync_in(rx_frame_sync_in),
        .i_rx_channel_data_in(rdi), .i_adc_word(adc_word), .i_adc_valid(adc_valid),
        .o_adc_ready(ck[8]), .o_serial_bit_clock(ck[0]), .o_tx_channel_data_out(tdo),
        .o_rx_channel_data_out(rdo), .o_tx_data_clock_out(ck[1]),
        .o_tx_sample_clock_double(ck[2]), .o_tx_symbol_clock(ck[3]),
        .o_rx_data_clock_out(ck[4]), .o_rx_sample_clock_out(ck[5]), .o_rx_symbol_clock(ck[6]),
        .o_tx_timing_source(ck[7]), .o_dac_word(dac_word), .o_dac_valid(ck[9]),
        .o_rx_ctrl_word(rctl_word), .o_rx_ctrl_valid(ck[10]));
    mcg_host_model HOST (.i_clk_sys(clk), .i_sclk(ck[0]), .i_tx_do(tdo), .i_rx_do(rdo),
        .o_tx_fs(tx_frame_sync_in), .o_rx_fs(rx_frame_sync_in), .o_tx_di(tdi), .o_rx_di(rdi));

    function automatic int hp(int r);
        int h;
        h = (CLK_HZ / r + 1) / 2;
        return (h < 4) ? 4 : h;
    endfunction : hp

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic t_rates(input logic [3:0] ts, rs, input logic [4:0] td, rd);
        int n;
        int e [6];
        e = '{hp(SYM[ts]), hp(DAT[td]), hp(SYM[rs]), hp(DAT[rd]), hp(2 * SMP), hp(SMP)};
        @(posedge clk);
        tsym <= ts;
        tdat <= td;
        rsym <= rs;
        rdat <= rd;
        for (int w = 0; w < 6; w++) begin
            n = 0;
            while (ck[MAP[w]] !== 1'b0) @(negedge clk);
            while (ck[MAP[w]] !== 1'b1) @(negedge clk);
            while (ck[MAP[w]] === 1'b1) begin
                @(negedge clk);
                n++;
            end
            chk(16'(n), 16'(e[w]));
        end
        $display("rates test done");
    endtask : t_rates

    task automatic push(input logic [15:0] w);
        int k = 0;
        adc_valid <= 1'b1;
        adc_word <= w;
        do begin
            @(posedge clk);
            k++;
        end while (ck[8] !== 1'b1 && k < 50);
    endtask : push

    task automatic t_serial();
        logic [15:0] gt, gr;
        logic [15:0] wt [3] = '{16'hc35a, 16'h00ff, 16'h8000};
        logic [15:0] wr [3] = '{16'h1234, 16'hff00, 16'h7fff};
        logic [15:0] ad [3] = '{16'h8001, 16'h7ffe, 16'h0000};
        @(posedge clk);
        push(ad[0]);
        push(ad[1]);
        adc_valid <= 1'b0;
        repeat (3) @(negedge clk);
        chk(ck[8], 1'b0);
        for (int k = 0; k < 3; k++) begin
            HOST.xfer(wt[k], wr[k], gt, gr);
            #1;
            chk({ck[9], ck[10]}, 2'b11);
            chk(dac_word, wt[k]);
            chk(rctl_word, wr[k]);
            chk(gt, (k == 0) ? 16'h0000 : wt[k-1]);
            chk(gr, ad[k]);
        end
        $display("serial test done");
    endtask : t_serial

    // Step requested early in a low phase lands at the end of the next high phase
    task automatic t_step(input logic dir);
        int hi, lo;
        hi = 0;
        lo = 0;
        while (ck[5] !== 1'b1) @(negedge clk);
        while (ck[5] !== 1'b0) @(negedge clk);
        @(posedge clk);
        step_dir <= dir;
        step_req <= 1'b1;
        @(posedge clk);
        step_req <= 1'b0;
        while (ck[5] !== 1'b1) @(negedge clk);
        while (ck[5] === 1'b1) begin
            @(negedge clk);
            hi++;
        end
        while (ck[5] === 1'b0) begin
            @(negedge clk);
            lo++;
        end
        chk(16'(hi), 16'(hp(SMP) + !dir));
        chk(16'(lo), 16'(hp(SMP) - dir));
        $display("step test done");
    endtask : t_step

    // One external rise early in a transmit data clock phase of level lvl
    task automatic t_edge(input logic lvl, input int dn);
        int n;
        while (ck[1] !== !lvl) @(negedge clk);
        while (ck[1] !== lvl) @(negedge clk);
        @(posedge clk);
        ext_clk <= 1'b1;
        n = 0;
        while (ck[1] === lvl) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        ext_clk <= 1'b0;
        chk(16'(n), 16'(hp(DAT[tdat]) + dn));
    endtask : t_edge

    // Data rate kept so no divider sees a shorter half period mid-phase
    task automatic t_track();
        @(posedge clk);
        mode <= mcg_pkg::MCG_TX_SLAVE;
        t_edge(1'b0, -1);
        t_edge(1'b0, -2);
        t_edge(1'b1, 1);
        @(posedge clk);
        mode <= mcg_pkg::MCG_TX_FREE;
        t_edge(1'b0, 0);
        $display("track test done");
    endtask : t_track

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        {rst_n, adc_valid, adc_word, ext_clk, step_req, step_dir} = '0;
        {tsym, tdat, rsym, rdat} = {4'ha, 5'h11, 4'h0, 5'h05};
        mode = mcg_pkg::MCG_TX_MASTER;
        repeat (2) @(negedge clk);
        chk(ck, 11'h180);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(ck[6:0], 7'h7f);
        t_rates(4'ha, 4'h0, 5'h11, 5'h05);
        t_rates(4'h4, 4'h6, 5'h00, 5'h09);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk);
            mode <= mcg_pkg::mcg_tx_mode_e'(m);
            repeat (3) @(negedge clk);
            chk(ck[7], m == 0);
        end
        $display("mode test done");
        t_serial();
        t_step(1'b0);
        t_step(1'b1);
        t_track();
        test_done();
    end
endmodule : tb_modem_afe_clock_dpll_generator
